// File: logic/mbm_pkg.sv
// Address map, connectivity and decode shared by the bus matrix
`default_nettype none
package mbm_pkg;

	localparam int NUM_MASTERS = 4;
	localparam int NUM_SLAVES = 5;
	localparam int SLV_W = 3;

	localparam logic [1:0] MST_INSTR = 2'h0;
	localparam logic [1:0] MST_SYS = 2'h1;
	localparam logic [1:0] MST_DMA = 2'h2;
	localparam logic [1:0] MST_CRC = 2'h3;

	localparam logic [2:0] SLV_SRAM = 3'h0;
	localparam logic [2:0] SLV_ROM = 3'h1;
	localparam logic [2:0] SLV_FLASH = 3'h2;
	localparam logic [2:0] SLV_EBI = 3'h3;
	localparam logic [2:0] SLV_PBRIDGE = 3'h4;

	localparam logic [31:0] BOOT_SIZE = 32'h0040_0000;
	localparam logic [31:0] ROM_BASE = 32'h0080_0000;
	localparam logic [31:0] ROM_SIZE = 32'h0010_0000;
	localparam logic [31:0] FLASH_BASE = 32'h0040_0000;
	localparam logic [31:0] FLASH1_BASE = 32'h0050_0000;
	localparam logic [31:0] FLASH_SIZE = 32'h0020_0000;
	localparam int FLASH_BANK_BIT = 20;
	localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
	localparam logic [31:0] SRAM_SIZE = 32'h0002_8000;
	localparam logic [31:0] BB_BASE = 32'h2200_0000;
	localparam logic [31:0] BB_LAST = 32'h23ff_ffff;
	localparam logic [31:0] PB_BASE = 32'h4000_0000;
	localparam logic [31:0] PB_SIZE = 32'h2000_0000;
	localparam logic [31:0] EBI_BASE = 32'h6000_0000;
	localparam logic [31:0] EBI_SIZE = 32'h2000_0000;

	localparam int NV_BOOT = 1;
	localparam int NV_SWAP = 2;

	// Row per slave, bit per master
	localparam logic [4:0][3:0] CONN = {4'h6, 4'he, 4'h9, 4'hd, 4'he};

	typedef struct packed {
		logic hit;
		logic [2:0] slv;
		logic [31:0] loc;
		logic bb;
		logic [2:0] bit_sel;
	} mbm_dec_t;

	function automatic mbm_dec_t mbm_decode(input logic [31:0] a,
		input logic [2:0] nv);
		mbm_dec_t d;
		logic [31:0] off;
		d = '0;
		off = '0;
		if (a < BOOT_SIZE) begin
			if (nv[NV_BOOT] && a < FLASH_SIZE) begin
				d.hit = 1'b1;
				d.slv = SLV_FLASH;
				d.loc = a;
				d.loc[FLASH_BANK_BIT] = a[FLASH_BANK_BIT] ^ nv[NV_SWAP];
			end else if (!nv[NV_BOOT] && a < ROM_SIZE) begin
				d.hit = 1'b1;
				d.slv = SLV_ROM;
				d.loc = a;
			end
		end else if (a >= ROM_BASE && a - ROM_BASE < ROM_SIZE) begin
			d.hit = 1'b1;
			d.slv = SLV_ROM;
			d.loc = a - ROM_BASE;
		end else if (a >= FLASH_BASE && a - FLASH_BASE < FLASH_SIZE) begin
			off = a - FLASH_BASE;
			d.hit = 1'b1;
			d.slv = SLV_FLASH;
			d.loc = off;
			d.loc[FLASH_BANK_BIT] = off[FLASH_BANK_BIT] ^ nv[NV_SWAP];
		end else if (a >= SRAM_BASE && a - SRAM_BASE < SRAM_SIZE) begin
			d.hit = 1'b1;
			d.slv = SLV_SRAM;
			d.loc = a - SRAM_BASE;
		end else if (a >= BB_BASE && a <= BB_LAST) begin
			off = a - BB_BASE;
			// One alias word per SRAM bit: byte = off/32, bit = off[4:2]
			d.loc = {5'h00, off[31:5]};
			d.hit = d.loc < SRAM_SIZE;
			d.slv = SLV_SRAM;
			d.bb = 1'b1;
			d.bit_sel = off[4:2];
		end else if (a >= PB_BASE && a - PB_BASE < PB_SIZE) begin
			d.hit = 1'b1;
			d.slv = SLV_PBRIDGE;
			d.loc = a - PB_BASE;
		end else if (a >= EBI_BASE && a - EBI_BASE < EBI_SIZE) begin
			d.hit = 1'b1;
			d.slv = SLV_EBI;
			d.loc = a - EBI_BASE;
		end
		return d;
	endfunction : mbm_decode

endpackage : mbm_pkg
`default_nettype wire

// File: logic/mbm_rr_arbiter.sv
// Round-robin arbiter for one slave port of the bus matrix
`timescale 1ns/1ps
`default_nettype none
module mbm_rr_arbiter #(
	parameter int N = 4
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [N-1:0] req,
	input wire logic xfer_end,
	output logic [N-1:0] grant_q
);

	localparam int LW = $clog2(N);

	logic [LW-1:0] last_q;
	logic [N-1:0] pick;
	logic [LW-1:0] pick_idx;
	logic found;
	int idx;

	// Search starts just after the last winner
	always_comb begin
		pick = '0;
		pick_idx = '0;
		found = 1'b0;
		idx = 0;
		for (int i = 1; i <= N; i++) begin
			idx = (int'(last_q) + i) % N;
			if (!found && req[idx]) begin
				pick[idx] = 1'b1;
				pick_idx = LW'(idx);
				found = 1'b1;
			end
		end
	end

	// Grant held until the transfer ends, then freed for a new pick
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			grant_q <= '0;
		end else if (xfer_end) begin
			grant_q <= '0;
		end else if (grant_q == '0) begin
			grant_q <= pick;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			last_q <= '0;
		end else if (grant_q == '0 && found && !xfer_end) begin
			last_q <= pick_idx;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	grant_onehot_a: assert property ($onehot0(grant_q))
		else $error("arbiter granted more than one master");

	grant_hold_a: assert property (
		(grant_q != '0 && !xfer_end) |=> $stable(grant_q))
		else $error("grant changed during a transfer");

	grant_pick_a: assert property (
		(grant_q == '0 && req != '0 && !xfer_end)
		|=> (grant_q & $past(req)) != '0)
		else $error("idle arbiter ignored a request");

endmodule : mbm_rr_arbiter
`default_nettype wire

// File: logic/mbm_bus_matrix.sv
// Four-master, five-slave bus matrix with per-master decode
`timescale 1ns/1ps
`default_nettype none
module mbm_bus_matrix
	import mbm_pkg::*;
#(
	parameter int DW = 32
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [2:0] boot_select_nv_bit,
	input wire logic [NUM_MASTERS-1:0] m_req,
	input wire logic [NUM_MASTERS-1:0][31:0] m_addr,
	input wire logic [NUM_MASTERS-1:0] m_write,
	input wire logic [NUM_MASTERS-1:0][DW-1:0] m_wdata,
	output logic [NUM_MASTERS-1:0] m_done_q,
	output logic [NUM_MASTERS-1:0] m_err_q,
	output logic [NUM_MASTERS-1:0][DW-1:0] m_rdata_q,
	output logic [NUM_SLAVES-1:0] s_sel_q,
	output logic [NUM_SLAVES-1:0][31:0] s_addr_q,
	output logic [NUM_SLAVES-1:0] s_write_q,
	output logic [NUM_SLAVES-1:0][DW-1:0] s_wdata_q,
	output logic [NUM_SLAVES-1:0] s_bitband_q,
	output logic [NUM_SLAVES-1:0][2:0] s_bit_q,
	input wire logic [NUM_SLAVES-1:0] s_done,
	input wire logic [NUM_SLAVES-1:0][DW-1:0] s_rdata
);

	localparam int NM = NUM_MASTERS;
	localparam int NS = NUM_SLAVES;

	mbm_dec_t dec [NM];
	logic [NM-1:0] accept;
	logic [NM-1:0] ok;
	logic [NM-1:0] pend_q;
	logic [NM-1:0][2:0] tgt_q;
	logic [NM-1:0][31:0] loc_q;
	logic [NM-1:0] wr_q;
	logic [NM-1:0][DW-1:0] wdata_q;
	logic [NM-1:0] bb_q;
	logic [NM-1:0][2:0] bit_q;

	logic [NS-1:0][NM-1:0] arb_req;
	logic [NS-1:0][NM-1:0] grant;
	logic [NS-1:0] start;
	logic [NS-1:0] fin;
	logic [NS-1:0][31:0] mx_addr;
	logic [NS-1:0] mx_write;
	logic [NS-1:0][DW-1:0] mx_wdata;
	logic [NS-1:0] mx_bb;
	logic [NS-1:0][2:0] mx_bit;

	logic [NM-1:0] resp;
	logic [NM-1:0][DW-1:0] resp_data;

	// Master side: one decoder and one request slot per port
	genvar gm;
	generate
		for (gm = 0; gm < NM; gm++) begin : g_mst
			assign dec[gm] = mbm_decode(m_addr[gm], boot_select_nv_bit);
			// A blocked pairing counts as unmapped for this master
			assign ok[gm] = dec[gm].hit && CONN[dec[gm].slv][gm];
			// Done pulse still visible: master has not yet dropped req
			assign accept[gm] = m_req[gm] && !pend_q[gm] && !m_done_q[gm];

			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					pend_q[gm] <= 1'b0;
				end else if (accept[gm] && ok[gm]) begin
					pend_q[gm] <= 1'b1;
				end else if (resp[gm]) begin
					pend_q[gm] <= 1'b0;
				end
			end

			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					tgt_q[gm] <= '0;
					loc_q[gm] <= '0;
					wr_q[gm] <= 1'b0;
					wdata_q[gm] <= '0;
					bb_q[gm] <= 1'b0;
					bit_q[gm] <= '0;
				end else if (accept[gm]) begin
					tgt_q[gm] <= dec[gm].slv;
					loc_q[gm] <= dec[gm].loc;
					wr_q[gm] <= m_write[gm];
					wdata_q[gm] <= m_wdata[gm];
					bb_q[gm] <= dec[gm].bb;
					bit_q[gm] <= dec[gm].bit_sel;
				end
			end

			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					m_done_q[gm] <= 1'b0;
					m_err_q[gm] <= 1'b0;
				end else begin
					m_done_q[gm] <= (accept[gm] && !ok[gm]) || resp[gm];
					m_err_q[gm] <= accept[gm] && !ok[gm];
				end
			end

			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					m_rdata_q[gm] <= '0;
				end else if (resp[gm]) begin
					m_rdata_q[gm] <= resp_data[gm];
				end
			end

			// Only permitted slaves feed the return path
			always_comb begin
				resp[gm] = 1'b0;
				resp_data[gm] = '0;
				for (int s = 0; s < NS; s++) begin
					if (CONN[s][gm] && fin[s] && grant[s][gm]) begin
						resp[gm] = 1'b1;
						resp_data[gm] = s_rdata[s];
					end
				end
			end
		end
	endgenerate

	// Slave side: independent arbiter and launch per slave
	genvar gs;
	generate
		for (gs = 0; gs < NS; gs++) begin : g_slv
			always_comb begin
				for (int m = 0; m < NM; m++) begin
					arb_req[gs][m] = CONN[gs][m] && pend_q[m] &&
						tgt_q[m] == SLV_W'(gs);
				end
			end

			mbm_rr_arbiter #(
				.N(NM)
			) u_arb (
				.clock(clock),
				.rst_b(rst_b),
				.req(arb_req[gs]),
				.xfer_end(fin[gs]),
				.grant_q(grant[gs])
			);

			assign start[gs] = grant[gs] != '0 && !s_sel_q[gs];
			assign fin[gs] = s_sel_q[gs] && s_done[gs];

			// Forbidden masters never reach the mux: no wiring is built
			always_comb begin
				mx_addr[gs] = '0;
				mx_write[gs] = 1'b0;
				mx_wdata[gs] = '0;
				mx_bb[gs] = 1'b0;
				mx_bit[gs] = '0;
				for (int m = 0; m < NM; m++) begin
					if (CONN[gs][m] && grant[gs][m]) begin
						mx_addr[gs] = loc_q[m];
						mx_write[gs] = wr_q[m];
						mx_wdata[gs] = wdata_q[m];
						mx_bb[gs] = bb_q[m];
						mx_bit[gs] = bit_q[m];
					end
				end
			end

			// Every slave, bridge included, runs on this one clock
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					s_sel_q[gs] <= 1'b0;
				end else if (start[gs]) begin
					s_sel_q[gs] <= 1'b1;
				end else if (fin[gs]) begin
					s_sel_q[gs] <= 1'b0;
				end
			end

			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					s_addr_q[gs] <= '0;
					s_write_q[gs] <= 1'b0;
					s_wdata_q[gs] <= '0;
					s_bitband_q[gs] <= 1'b0;
					s_bit_q[gs] <= '0;
				end else if (start[gs]) begin
					s_addr_q[gs] <= mx_addr[gs];
					s_write_q[gs] <= mx_write[gs];
					s_wdata_q[gs] <= mx_wdata[gs];
					s_bitband_q[gs] <= mx_bb[gs];
					s_bit_q[gs] <= mx_bit[gs];
				end
			end
		end
	endgenerate

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	generate
		for (gm = 0; gm < NM; gm++) begin : g_mchk
			sequence acc_hit_s;
				accept[gm] && ok[gm];
			endsequence

			sequence acc_miss_s;
				accept[gm] && !ok[gm];
			endsequence

			unmapped_err_a: assert property (
				acc_miss_s |=> m_done_q[gm] && m_err_q[gm] && !pend_q[gm])
				else $error("bad access did not end in bus error");

			hit_pending_a: assert property (
				acc_hit_s |=> pend_q[gm] && !m_done_q[gm] ##1 !m_err_q[gm])
				else $error("mapped access did not become pending");

			sram_route_a: assert property (
				(acc_hit_s and (m_addr[gm] >= SRAM_BASE &&
				m_addr[gm] < SRAM_BASE + SRAM_SIZE))
				|=> tgt_q[gm] == SLV_SRAM && !bb_q[gm] &&
				loc_q[gm] == $past(m_addr[gm]) - SRAM_BASE)
				else $error("SRAM window decoded wrongly");

			bitband_map_a: assert property (
				(acc_hit_s and (m_addr[gm] >= BB_BASE &&
				m_addr[gm] <= BB_LAST))
				|=> bb_q[gm] && tgt_q[gm] == SLV_SRAM &&
				bit_q[gm] == $past(m_addr[gm][4:2]))
				else $error("bit-band alias decoded wrongly");

			rom_fixed_a: assert property (
				(accept[gm] && CONN[SLV_ROM][gm] && m_addr[gm] == ROM_BASE)
				|=> pend_q[gm] && tgt_q[gm] == SLV_ROM && loc_q[gm] == '0)
				else $error("ROM base moved with boot setting");

			boot_alias_a: assert property (
				(acc_hit_s and (m_addr[gm] == '0)) |=> tgt_q[gm] ==
				($past(boot_select_nv_bit[NV_BOOT]) ? SLV_FLASH : SLV_ROM))
				else $error("address zero aliased to wrong memory");

			flash_swap_a: assert property (
				(acc_hit_s and (m_addr[gm] == FLASH1_BASE))
				|=> tgt_q[gm] == SLV_FLASH && loc_q[gm][FLASH_BANK_BIT] ==
				!$past(boot_select_nv_bit[NV_SWAP]))
				else $error("Flash bank order wrong");

			flash_window_a: assert property (
				(acc_hit_s and (m_addr[gm] >= FLASH_BASE &&
				m_addr[gm] < FLASH_BASE + FLASH_SIZE))
				|=> tgt_q[gm] == SLV_FLASH &&
				loc_q[gm][FLASH_BANK_BIT-1:0] ==
				$past(m_addr[gm][FLASH_BANK_BIT-1:0]))
				else $error("Flash window decoded wrongly");

			err_pulse_a: assert property (
				m_err_q[gm] |-> m_done_q[gm] ##1 !m_done_q[gm])
				else $error("bus error not a single done pulse");
		end

		for (gs = 0; gs < NS; gs++) begin : g_schk
			sequence launch_s;
				start[gs] ##1 s_sel_q[gs];
			endsequence

			launch_addr_a: assert property (
				start[gs] |=> s_sel_q[gs] && s_addr_q[gs] == $past(mx_addr[gs]))
				else $error("slave launch lost its address");

			sel_hold_a: assert property (
				launch_s ##0 !s_done[gs] |=> s_sel_q[gs] && $stable(grant[gs]))
				else $error("slave select dropped before completion");

			sel_release_a: assert property (
				fin[gs] |=> !s_sel_q[gs] && grant[gs] == '0)
				else $error("slave kept after its completion");

			for (genvar m = 0; m < NM; m++) begin : g_pair
				if (!CONN[gs][m]) begin : g_block
					no_path_a: assert property (!grant[gs][m])
						else $error("forbidden master granted a slave");
				end else begin : g_route
					return_a: assert property (
						(fin[gs] && grant[gs][m]) |=> m_done_q[m] &&
						!m_err_q[m] && m_rdata_q[m] == $past(s_rdata[gs]))
						else $error("slave completion not returned");
				end
			end
		end
	endgenerate

endmodule : mbm_bus_matrix
`default_nettype wire

// File: dv/mbm_slave_model.sv
// Behavioural model of the five slaves that answer the matrix
`timescale 1ns/1ps
`default_nettype none
module mbm_slave_model
	import mbm_pkg::*;
(
	input wire logic clock,
	input wire logic [NUM_SLAVES-1:0] slow,
	input wire logic [NUM_SLAVES-1:0] s_sel_q,
	input wire logic [NUM_SLAVES-1:0][31:0] s_addr_q,
	output logic [NUM_SLAVES-1:0] s_done,
	output logic [NUM_SLAVES-1:0][31:0] s_rdata
);
	logic [NUM_SLAVES-1:0][3:0] cnt_q;
	always_ff @(posedge clock) begin
		for (int s = 0; s < NUM_SLAVES; s++) begin
			cnt_q[s] <= s_sel_q[s] ? cnt_q[s] + 4'h1 : 4'h0;
		end
	end
	// Data outside the done cycle is inverted so stale values never match
	always_comb begin
		for (int s = 0; s < NUM_SLAVES; s++) begin
			s_done[s] = s_sel_q[s] && cnt_q[s] == (slow[s] ? 4'h4 : 4'h1);
			s_rdata[s] = {3'(s), 1'b0, s_addr_q[s][27:0]};
			if (!s_done[s]) begin
				s_rdata[s] = ~s_rdata[s];
			end
		end
	end
endmodule : mbm_slave_model
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the four-master bus matrix
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import mbm_pkg::*;
	localparam int LIMIT = 3000;
	logic clock, rst_b;
	logic [2:0] nv;
	logic [3:0] m_req, m_write, m_done_q, m_err_q;
	logic [3:0][31:0] m_addr, m_wdata, m_rdata_q;
	logic [4:0] s_sel_q, s_write_q, s_bitband_q, s_done, slow;
	logic [4:0][31:0] s_addr_q, s_wdata_q, s_rdata;
	logic [4:0][2:0] s_bit_q;
	int fail_count, cmp_count, cyc;
	int t_end [4];
	int lat [4];

	mbm_bus_matrix i_mbm_bus_matrix (.clock(clock), .rst_b(rst_b),
		.boot_select_nv_bit(nv), .m_req(m_req), .m_addr(m_addr),
		.m_write(m_write), .m_wdata(m_wdata), .m_done_q(m_done_q),
		.m_err_q(m_err_q), .m_rdata_q(m_rdata_q), .s_sel_q(s_sel_q),
		.s_addr_q(s_addr_q), .s_write_q(s_write_q), .s_wdata_q(s_wdata_q),
		.s_bitband_q(s_bitband_q), .s_bit_q(s_bit_q), .s_done(s_done),
		.s_rdata(s_rdata));
	mbm_slave_model i_mbm_slave_model (.clock(clock), .slow(slow),
		.s_sel_q(s_sel_q), .s_addr_q(s_addr_q), .s_done(s_done),
		.s_rdata(s_rdata));

	task automatic conclude();
		$display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic do_reset();
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
	endtask : do_reset

	// One transfer; slave model echoes slave index and local offset
	task automatic acc(input int m, input logic [31:0] a, input logic wr,
		input logic err, input logic [2:0] slv, input logic [31:0] loc,
		input logic [3:0] bb);
		int n;
		logic [4:0] cap;
		logic [31:0] wcap;
		n = 0;
		cap = '0;
		wcap = '0;
		@(posedge clock);
		m_req[m] <= 1'b1;
		m_addr[m] <= a;
		m_write[m] <= wr;
		m_wdata[m] <= ~a;
		do begin
			@(posedge clock);
			#1;
			n++;
			if (s_sel_q[slv]) begin
				cap = {s_write_q[slv], s_bitband_q[slv], s_bit_q[slv]};
				wcap = s_wdata_q[slv];
			end
		end while (m_done_q[m] !== 1'b1 && n < 40);
		t_end[m] = cyc;
		lat[m] = n;
		check({m_done_q[m], m_err_q[m]}, {1'b1, err});
		if (err) begin
			check(n, 1);
		end else begin
			check(m_rdata_q[m], {slv, 1'b0, loc[27:0]});
			check(cap, {wr, bb});
			check(wcap, ~a);
		end
		@(posedge clock);
		m_req[m] <= 1'b0;
	endtask : acc

	task automatic t_map();
		acc(1, 32'h2000_0000, 1, 0, SLV_SRAM, 0, 0);
		acc(2, 32'h2002_7ffc, 0, 0, SLV_SRAM, 32'h2_7ffc, 0);
		acc(2, 32'h2002_8000, 0, 1, 0, 0, 0);
		acc(3, 32'h2200_0024, 0, 0, SLV_SRAM, 1, 4'h9);
		acc(3, 32'h23ff_fffc, 0, 1, 0, 0, 0);
		acc(0, 32'h0080_0010, 0, 0, SLV_ROM, 32'h10, 0);
		acc(0, 32'h0040_0000, 0, 0, SLV_FLASH, 0, 0);
		acc(0, 32'h0050_0000, 0, 0, SLV_FLASH, 32'h10_0000, 0);
		acc(3, 32'h005f_fffc, 1, 0, SLV_FLASH, 32'h1f_fffc, 0);
		acc(3, 32'h0060_0000, 0, 1, 0, 0, 0);
		acc(1, 32'h4000_0020, 0, 0, SLV_PBRIDGE, 32'h20, 0);
		acc(1, 32'h1000_0000, 0, 1, 0, 0, 0);
		$display("t_map finished");
	endtask : t_map

	task automatic t_conn();
		logic [4:0][31:0] base;
		logic [4:0][3:0] ok;
		base = {32'h4000_0100, 32'h6000_0100, 32'h0040_0100,
			32'h0080_0100, 32'h2000_0100};
		ok = {4'h6, 4'he, 4'h9, 4'hd, 4'he};
		for (int s = 0; s < 5; s++) begin
			for (int m = 0; m < 4; m++) begin
				acc(m, base[s], 0, !ok[s][m], 3'(s), 32'h100, 0);
			end
		end
		$display("t_conn finished");
	endtask : t_conn

	task automatic t_boot();
		acc(0, 32'h0, 0, 0, SLV_ROM, 32'h0, 0);
		nv <= 3'h2;
		acc(0, 32'h0, 0, 0, SLV_FLASH, 32'h0, 0);
		acc(0, 32'h0080_0000, 0, 0, SLV_ROM, 32'h0, 0);
		nv <= 3'h6;
		acc(0, 32'h4, 0, 0, SLV_FLASH, 32'h10_0004, 0);
		acc(3, 32'h0050_0000, 0, 0, SLV_FLASH, 32'h0, 0);
		nv <= 3'h0;
		$display("t_boot finished");
	endtask : t_boot

	task automatic t_conc();
		slow <= 5'h01;
		fork
			acc(1, 32'h2000_0040, 0, 0, SLV_SRAM, 32'h40, 0);
			acc(0, 32'h0080_0040, 0, 0, SLV_ROM, 32'h40, 0);
		join
		// Accept, grant, launch, one slave cycle, done edge
		check(lat[0], 5);
		check(t_end[0] < t_end[1], 1);
		$display("t_conc finished");
	endtask : t_conc

	// Fresh reset puts the round-robin pointer at master 0
	task automatic t_arb();
		do_reset();
		fork
			acc(1, 32'h2000_0010, 0, 0, SLV_SRAM, 32'h10, 0);
			acc(2, 32'h2000_0010, 0, 0, SLV_SRAM, 32'h10, 0);
			acc(3, 32'h2000_0010, 0, 0, SLV_SRAM, 32'h10, 0);
		join
		check(t_end[1] < t_end[2], 1);
		check(t_end[2] < t_end[3], 1);
		slow <= 5'h00;
		$display("t_arb finished");
	endtask : t_arb

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fail_count++;
			conclude();
		end
	end

	initial begin
		rst_b = 1'b0;
		nv = 3'h0;
		m_req = 4'h0;
		m_addr = '0;
		m_write = 4'h0;
		m_wdata = '0;
		slow = 5'h00;
		fail_count = 0;
		cmp_count = 0;
		cyc = 0;
		do_reset();
		t_map();
		t_conn();
		t_boot();
		t_conc();
		t_arb();
		conclude();
	end
endmodule : tb_top
`default_nettype wire
